/* File: hw/adcseq_top.sv */
// conversion sequencer: modulator clock, input routing, decimator
// assumes a 250 MHz clk, async active-high reset, host on a plain port
//
// Contract
// - one-shot request runs exactly one conversion
// - after one-shot result, power down until request
// - continuous mode restarts immediately, no gap
// - continuous results arrive at programmed data rate
// - result register holds latest completed conversion
// - three-bit field selects the converter inputs
// - four single-ended inputs or four differential pairs
// - first three inputs against the fourth input
// - single-ended ties negative input to ground
// - single-ended selections never give negative codes
// - modulator clock is oscillator divided by four
// - filter turns bitstream into 16-bit code
// - decimation equals modulator rate over data rate
// - mode bit 0 continuous, 1 one-shot
// - start bit powers up, self-clears, converts once
// - start written while busy is ignored
// - reset restores defaults and powers down
`timescale 1ns/10ps
`include "adcseq_defs.svh"
module adcseq_top
#(
	parameter int OSC_CYCLES = `ADCSEQ_OSC_CYCLES,
	parameter int BUF_DEPTH  = 2
)
(
	// clocking
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	// register port
	input  wire logic [1:0]  addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        wr_strobe,
	input  wire logic        rd_strobe,
	output logic [15:0]      rd_data,
	// modulator side
	input  wire logic        mod_bit_in,
	output logic             mod_clk,
	output logic [1:0]       converter_positive_input,
	output logic [1:0]       converter_negative_input,
	output logic             neg_to_gnd,
	output logic [2:0]       gain_out,
	output logic             powered_down,
	// result stream
	output logic             res_valid,
	input  wire logic        res_ready,
	output logic [15:0]      res_data
);

	adcseq_pkg::adcseq_state_type state_reg, state_next;
	adcseq_pkg::adcseq_cfg_type   cfg_reg, cfg_lat_reg, cfg_wr;
	adcseq_pkg::adcseq_route_type route_wr, route_lat;
	logic        mode_reg, start_reg, busy_reg;
	logic [15:0] result_reg, code;
	logic [8:0]  osc_cnt_reg;
	logic [1:0]  mod_cnt_reg;
	logic        osc_tick, mod_tick;
	logic        sync1_reg, sync2_reg;
	logic [14:0] sample_cnt_reg, ones_cnt_reg, dec_n;
	logic [22:0] scale;
	logic        last_sample, start_conv, push, buf_ready;
	logic        cfg_write, start_write;
	logic signed [16:0] diff;
	logic signed [40:0] prod;
	logic signed [24:0] code_wide;

	// input routing from the select field
	function automatic adcseq_pkg::adcseq_route_type route_of(
		input logic [2:0] mux);
		adcseq_pkg::adcseq_route_type r;
		r.neg_to_gnd = mux[2];
		r.pos_sel    = (mux[2] || mux == 3'h0 || mux == 3'h1)
			? (mux[2] ? mux[1:0] : 2'h0) : mux[1:0] - 2'h1;
		r.neg_sel    = (mux == 3'h0) ? 2'h1 : 2'h3;
		return r;
	endfunction

	// samples per result for each data-rate code
	function automatic logic [14:0] dec_of(input logic [2:0] rate);
		case (rate)
			3'h0: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS0);
			3'h1: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS1);
			3'h2: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS2);
			3'h3: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS3);
			3'h4: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS4);
			3'h5: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS5);
			3'h6: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS6);
			default: return 15'(`ADCSEQ_MOD_HZ / `ADCSEQ_SPS7);
		endcase
	endfunction

	// register decode and write field extraction
	assign cfg_write   = wr_strobe && addr == `ADCSEQ_ADDR_CONFIG;
	assign start_write = cfg_write && wr_data[`ADCSEQ_START_BIT];
	assign cfg_wr.mux  = wr_data[`ADCSEQ_MUX_LSB +: 3];
	assign cfg_wr.gain = wr_data[`ADCSEQ_GAIN_LSB +: 3];
	assign cfg_wr.rate = wr_data[`ADCSEQ_RATE_LSB +: 3];
	assign route_wr    = route_of(cfg_reg.mux);
	assign route_lat   = route_of(cfg_lat_reg.mux);

	// oscillator tick and divide-by-four modulator tick
	assign osc_tick = osc_cnt_reg == 9'(OSC_CYCLES - 1);
	assign mod_tick = osc_tick && mod_cnt_reg == 2'(`ADCSEQ_MOD_DIV - 1);

	// decimator: count ones, scale to a signed 16-bit code
	assign dec_n       = dec_of(cfg_lat_reg.rate);
	assign scale       = 23'((64'h8000_0000 + {49'h0, dec_n} - 64'h1)
		/ {49'h0, dec_n});
	assign last_sample = state_reg == adcseq_pkg::ST_CONV && mod_tick
		&& sample_cnt_reg == dec_n - 15'h1;
	assign diff        = $signed({1'b0, ones_cnt_reg, 1'b0})
		- $signed({2'b00, dec_n});
	assign prod        = diff * $signed({1'b0, scale});
	assign code_wide   = prod[40:16];
	assign code = (route_lat.neg_to_gnd && code_wide < 0) ? 16'h0000
		: (code_wide > 25'sh7fff) ? 16'h7fff
		: (code_wide < -25'sh8000) ? 16'h8000
		: code_wide[15:0];

	// conversion sequencing
	assign push       = state_reg == adcseq_pkg::ST_STORE && buf_ready;
	assign start_conv = (state_reg == adcseq_pkg::ST_IDLE
		&& (!mode_reg || start_reg))
		|| (push && !mode_reg);

	// next-state selection
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			adcseq_pkg::ST_IDLE:
				if (start_conv)
					state_next = adcseq_pkg::ST_CONV;
			adcseq_pkg::ST_CONV:
				if (last_sample)
					state_next = adcseq_pkg::ST_STORE;
			adcseq_pkg::ST_STORE:
				if (push)
					state_next = mode_reg ? adcseq_pkg::ST_IDLE
						: adcseq_pkg::ST_CONV;
			default:
				state_next = adcseq_pkg::ST_IDLE;
		endcase
	end

	// two-flop synchroniser for the modulator bit
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end
		else if (ce)
		begin
			sync1_reg <= mod_bit_in;
			sync2_reg <= sync1_reg;
		end
	end

	// oscillator prescale and modulator clock divider
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			osc_cnt_reg <= 9'h000;
			mod_cnt_reg <= 2'h0;
			mod_clk     <= 1'b0;
		end
		else if (ce)
		begin
			osc_cnt_reg <= osc_tick ? 9'h000 : osc_cnt_reg + 9'h001;
			if (osc_tick)
			begin
				mod_cnt_reg <= mod_cnt_reg + 2'h1;
				mod_clk     <= ~mod_cnt_reg[1]; // two ticks high, two low
			end
		end
	end

	// host-visible configuration and one-shot start bit
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cfg_reg   <= {`ADCSEQ_MUX_RESET, `ADCSEQ_GAIN_RESET,
				`ADCSEQ_RATE_RESET};
			mode_reg  <= `ADCSEQ_MODE_RESET;
			start_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (cfg_write)
			begin
				cfg_reg  <= cfg_wr;
				mode_reg <= wr_data[`ADCSEQ_MODE_BIT];
			end
			if (start_write && !busy_reg && mode_reg)
				start_reg <= 1'b1;
			else if (start_conv)
				start_reg <= 1'b0;
		end
	end

	// sequencer state, counters and captured settings
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg      <= adcseq_pkg::ST_IDLE;
			busy_reg       <= 1'b0;
			cfg_lat_reg    <= {`ADCSEQ_MUX_RESET, `ADCSEQ_GAIN_RESET,
				`ADCSEQ_RATE_RESET};
			sample_cnt_reg <= 15'h0000;
			ones_cnt_reg   <= 15'h0000;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			busy_reg  <= state_next != adcseq_pkg::ST_IDLE;
			if (start_conv)
			begin
				cfg_lat_reg    <= cfg_reg;
				sample_cnt_reg <= 15'h0000;
				ones_cnt_reg   <= 15'h0000;
			end
			else if (state_reg == adcseq_pkg::ST_CONV && mod_tick)
			begin
				sample_cnt_reg <= sample_cnt_reg + 15'h0001;
				ones_cnt_reg   <= ones_cnt_reg + {14'h0000, sync2_reg};
			end
		end
	end

	// result, routing outputs and register read data
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			result_reg   <= 16'h0000;
			rd_data      <= 16'h0000;
			powered_down <= 1'b1;
			converter_positive_input <= 2'h0;
			converter_negative_input <= 2'h1;
			neg_to_gnd   <= 1'b0;
			gain_out     <= `ADCSEQ_GAIN_RESET;
		end
		else if (ce)
		begin
			if (push)
				result_reg <= code;
			powered_down <= state_next == adcseq_pkg::ST_IDLE;
			if (start_conv)
			begin
				converter_positive_input <= route_wr.pos_sel;
				converter_negative_input <= route_wr.neg_sel;
				neg_to_gnd   <= route_wr.neg_to_gnd;
				gain_out     <= cfg_reg.gain;
			end
			if (rd_strobe && addr == `ADCSEQ_ADDR_CONFIG)
				rd_data <= {5'h00, start_reg, mode_reg, cfg_reg.rate,
					cfg_reg.gain, cfg_reg.mux};
			else if (rd_strobe && addr == `ADCSEQ_ADDR_RESULT)
				rd_data <= result_reg;
			else if (rd_strobe && addr == `ADCSEQ_ADDR_STATUS)
				rd_data <= {13'h0000, res_valid, powered_down, busy_reg};
			else
				rd_data <= 16'h0000;
		end
	end

	// result stream buffer; a full buffer holds the sequencer in store
	adcseq_buffer #(
		.WIDTH (16),
		.DEPTH (BUF_DEPTH)
	) u_buffer (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.in_valid  (state_reg == adcseq_pkg::ST_STORE),
		.in_ready  (buf_ready),
		.in_data   (code),
		.out_valid (res_valid),
		.out_ready (res_ready),
		.out_data  (res_data)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (reset || !ce);

	sequence s_store_push;
		push;
	endsequence
	sequence s_conv_end;
		last_sample;
	endsequence

	property p_start_once;
		state_reg == adcseq_pkg::ST_IDLE && start_reg
		|=> busy_reg && !start_reg;
	endproperty
	a_start_once: assert property (p_start_once)
		else $error("one-shot start did not begin or self-clear");

	property p_oneshot_down;
		s_store_push and mode_reg
		|=> state_reg == adcseq_pkg::ST_IDLE && powered_down && !busy_reg;
	endproperty
	a_oneshot_down: assert property (p_oneshot_down)
		else $error("one-shot did not power down after store");

	property p_cont_restart;
		s_store_push and !mode_reg
		|=> state_reg == adcseq_pkg::ST_CONV && sample_cnt_reg == 15'h0000;
	endproperty
	a_cont_restart: assert property (p_cont_restart)
		else $error("continuous conversion did not restart at once");

	property p_busy_ignore;
		start_write && busy_reg |=> !start_reg;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore)
		else $error("start accepted while busy");

	property p_result_hold;
		!push |=> $stable(result_reg);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("result changed without a completed conversion");

	property p_se_positive;
		s_store_push and route_lat.neg_to_gnd |=> !result_reg[15];
	endproperty
	a_se_positive: assert property (p_se_positive)
		else $error("single-ended result is negative");

	property p_gnd_switch;
		state_reg == adcseq_pkg::ST_CONV |-> neg_to_gnd == cfg_lat_reg.mux[2]
			&& converter_positive_input == route_lat.pos_sel;
	endproperty
	a_gnd_switch: assert property (p_gnd_switch)
		else $error("input routing differs from captured select");

	property p_decimate;
		s_conv_end |=> state_reg == adcseq_pkg::ST_STORE
			&& sample_cnt_reg == dec_n;
	endproperty
	a_decimate: assert property (p_decimate)
		else $error("conversion ended at wrong sample count");

	property p_mod_div;
		osc_tick |=> mod_clk
			== (mod_cnt_reg == 2'h1 || mod_cnt_reg == 2'h2);
	endproperty
	a_mod_div: assert property (p_mod_div)
		else $error("modulator clock duty is not one half");

endmodule // adcseq_top

/* File: hw/adcseq_defs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the sequencer top module
`ifndef ADCSEQ_DEFS_SVH
`define ADCSEQ_DEFS_SVH

// register offsets on the plain register port
`define ADCSEQ_ADDR_CONFIG   2'h0
`define ADCSEQ_ADDR_RESULT   2'h1
`define ADCSEQ_ADDR_STATUS   2'h2

// configuration field positions
`define ADCSEQ_MUX_LSB       0
`define ADCSEQ_GAIN_LSB      3
`define ADCSEQ_RATE_LSB      6
`define ADCSEQ_MODE_BIT      9
`define ADCSEQ_START_BIT     10

// reset values: input pair 0, gain 2, rate 4, one-shot mode
`define ADCSEQ_MUX_RESET     3'h0
`define ADCSEQ_GAIN_RESET    3'h2
`define ADCSEQ_RATE_RESET    3'h4
`define ADCSEQ_MODE_RESET    1'h1

// timing: system clock, internal oscillator, modulator divider
`define ADCSEQ_CLK_PERIOD_NS 4
`define ADCSEQ_OSC_PERIOD_NS 1000
`define ADCSEQ_OSC_CYCLES    (`ADCSEQ_OSC_PERIOD_NS / `ADCSEQ_CLK_PERIOD_NS)
`define ADCSEQ_OSC_HZ        1000000
`define ADCSEQ_MOD_DIV       4
`define ADCSEQ_MOD_HZ        (`ADCSEQ_OSC_HZ / `ADCSEQ_MOD_DIV)

// selectable output data rates in samples per second
`define ADCSEQ_SPS0          8
`define ADCSEQ_SPS1          16
`define ADCSEQ_SPS2          32
`define ADCSEQ_SPS3          64
`define ADCSEQ_SPS4          128
`define ADCSEQ_SPS5          250
`define ADCSEQ_SPS6          475
`define ADCSEQ_SPS7          860

`endif

/* File: hw/adcseq_pkg.sv */
// types used by the conversion sequencer; the result buffer uses none
// assumes the defs header is on the include path
package adcseq_pkg;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CONV  = 2'b01,
		ST_STORE = 2'b10
	} adcseq_state_type;

	// settings sampled at the start of each conversion
	typedef struct packed {
		logic [2:0] mux;
		logic [2:0] gain;
		logic [2:0] rate;
	} adcseq_cfg_type;

	// analog switch routing for the converter inputs
	typedef struct packed {
		logic [1:0] pos_sel;
		logic [1:0] neg_sel;
		logic       neg_to_gnd;
	} adcseq_route_type;

endpackage

/* File: hw/adcseq_buffer.sv */
// shift-style result buffer with valid and ready on both sides
// assumes one clock, async active-high reset and a shared clock enable
`timescale 1ns/10ps
module adcseq_buffer
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
)
(
	// clocking
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	logic [WIDTH-1:0] data_reg [DEPTH];
	logic [DEPTH-1:0] valid_reg;
	logic [DEPTH-1:0] valid_shift;
	logic [DEPTH-1:0] load;
	logic             push;
	logic             pop;

	// handshakes; head entry feeds the output directly
	assign in_ready  = ~valid_reg[DEPTH-1];
	assign push      = in_valid & in_ready;
	assign pop       = valid_reg[0] & out_ready;
	assign out_valid = valid_reg[0];
	assign out_data  = data_reg[0];

	// per entry: shift toward the head on pop, load first free slot
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_entry
		if (i == DEPTH - 1)
		begin : g_last
			assign valid_shift[i] = pop ? 1'b0 : valid_reg[i];
		end
		else
		begin : g_mid
			assign valid_shift[i] = pop ? valid_reg[i+1] : valid_reg[i];
		end
		if (i == 0)
		begin : g_first
			assign load[i] = push & ~valid_shift[i];
		end
		else
		begin : g_rest
			assign load[i] = push & ~valid_shift[i] & valid_shift[i-1];
		end

		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
			begin
				valid_reg[i] <= 1'b0;
				data_reg[i]  <= '0;
			end
			else if (ce)
			begin
				valid_reg[i] <= valid_shift[i] | load[i];
				if (load[i])
					data_reg[i] <= in_data;
				else if (pop && i < DEPTH - 1)
					data_reg[i] <= data_reg[(i < DEPTH - 1) ? i + 1 : i];
			end
		end
	end

endmodule // adcseq_buffer

/* File: sim/adcseq_far_model.sv */
// far-side model: modulator bitstream source and result receiver
// assumes the bench sets pattern while the sequencer idles; stall may change mid-run
`timescale 1ns/10ps
module adcseq_far_model
(
	// modulator clock from the sequencer, control from the bench
	input  wire logic       mod_clk,
	input  wire logic [1:0] pattern,
	input  wire logic       stall,
	// toward the sequencer
	output logic            mod_bit,
	output logic            res_ready
);
	logic toggle_reg = 1'b0;

	// alternating stream flips on each modulator clock
	always @(posedge mod_clk)
		toggle_reg <= ~toggle_reg;

	// 0 all zeros, 1 all ones, else alternating; stall holds results back
	assign mod_bit   = (pattern == 2'h0) ? 1'b0 :
		(pattern == 2'h1) ? 1'b1 : toggle_reg;
	assign res_ready = ~stall;
endmodule // adcseq_far_model

/* File: sim/adcseq_tb_top.sv */
// self-checking bench for the conversion sequencer
// assumes OSC_CYCLES of 2, so one modulator tick is 8 clocks
`timescale 1ns/10ps
module adcseq_tb_top;
	typedef struct packed {
		logic [2:0]  rate;
		logic [2:0]  mux;
		logic        pat;
		logic [1:0]  pos;
		logic [1:0]  neg;
		logic        gnd;
		logic [15:0] code;
	} adcseq_row_type;

	logic           clk = 1'b0;
	logic           reset = 1'b1;
	logic           ce = 1'b1;
	logic [1:0]     addr = 2'h0;
	logic [15:0]    wr_data = 16'h0000;
	logic           wr_strobe = 1'b0;
	logic           rd_strobe = 1'b0;
	logic [1:0]     pattern = 2'h0;
	logic           stall = 1'b0;
	logic [15:0]    rd_data, res_data, rv, cfg;
	logic           mod_bit_in, mod_clk, neg_to_gnd, powered_down;
	logic           res_valid, res_ready, ok;
	logic [1:0]     pos_in, neg_in;
	logic [2:0]     gain_out;
	int             fails = 0;
	int             num_checks = 0;
	int             n, e;
	time            t0;
	adcseq_row_type r;
	// rate, mux, pattern, pos, neg, to-ground, expected code
	adcseq_row_type rows [8] = '{
		'{3'h7, 3'h0, 1'b0, 2'h0, 2'h1, 1'b0, 16'h8000},
		'{3'h7, 3'h1, 1'b1, 2'h0, 2'h3, 1'b0, 16'h7fff},
		'{3'h7, 3'h2, 1'b0, 2'h1, 2'h3, 1'b0, 16'h8000},
		'{3'h7, 3'h3, 1'b1, 2'h2, 2'h3, 1'b0, 16'h7fff},
		'{3'h6, 3'h4, 1'b0, 2'h0, 2'h0, 1'b1, 16'h0000},
		'{3'h5, 3'h5, 1'b1, 2'h1, 2'h0, 1'b1, 16'h7fff},
		'{3'h7, 3'h6, 1'b0, 2'h2, 2'h0, 1'b1, 16'h0000},
		'{3'h7, 3'h7, 1'b1, 2'h3, 2'h0, 1'b1, 16'h7fff}};

	// device under test and far side
	adcseq_top #(.OSC_CYCLES(2), .BUF_DEPTH(2)) adcseq_top_inst (
		.clk(clk), .reset(reset), .ce(ce), .addr(addr),
		.wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
		.rd_data(rd_data), .mod_bit_in(mod_bit_in), .mod_clk(mod_clk),
		.converter_positive_input(pos_in),
		.converter_negative_input(neg_in), .neg_to_gnd(neg_to_gnd),
		.gain_out(gain_out), .powered_down(powered_down),
		.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
	adcseq_far_model adcseq_far_model_inst (.mod_clk(mod_clk),
		.pattern(pattern), .stall(stall), .mod_bit(mod_bit_in),
		.res_ready(res_ready));

	// 250 MHz clock
	always #2 clk = ~clk;

	// compare one value
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle register write
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		addr      <= a;
		wr_data   <= d;
		wr_strobe <= 1'b1;
		@(posedge clk);
		wr_strobe <= 1'b0;
	endtask

	// one-cycle register read, data taken in the following cycle
	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		addr      <= a;
		rd_strobe <= 1'b1;
		@(posedge clk);
		rd_strobe <= 1'b0;
		#1;
		d = rd_data;
	endtask

	// bounded wait for a result word
	task automatic wait_valid();
		n = 0;
		while (res_valid !== 1'b1 && n < 20000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 20000)
			fails++;
	endtask

	// verdict
	task automatic tally_and_finish();
		if (fails == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog: the sequence needs about 60k clocks, allow 100k
	initial
	begin
		#400000;
		fails++;
		tally_and_finish();
	end

	// main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		chk({6'h00, powered_down, res_valid, neg_to_gnd, gain_out, pos_in,
			neg_in}, 16'h0221);
		rd(2'h0, rv);
		chk(rv, 16'h0310);
		rd(2'h3, rv);
		chk(rv, 16'h0000);
		// modulator clock: high in exactly half of two periods
		e = 0;
		repeat (16)
		begin
			@(posedge clk);
			#1;
			if (mod_clk === 1'b1)
				e++;
		end
		chk(16'(e), 16'h0008);
		rd(2'h1, rv);
		chk(rv, 16'h0000);
		repeat (3000) @(posedge clk);
		#1;
		chk({14'h0000, powered_down, res_valid}, 16'h0002);
		// one-shot conversion per row
		foreach (rows[i])
		begin
			r = rows[i];
			pattern <= {1'b0, r.pat};
			cfg = {7'h03, r.rate, ~r.mux, r.mux};
			wr(2'h0, cfg);
			t0 = $time;
			repeat (6) @(posedge clk);
			#1;
			chk({9'h000, powered_down, neg_to_gnd, gain_out, pos_in},
				{9'h000, 1'b0, r.gnd, ~r.mux, r.pos});
			if (!r.gnd)
				chk({14'h0000, neg_in}, {14'h0000, r.neg});
			rd(2'h0, rv);
			chk(rv, cfg & 16'h03ff);
			rd(2'h2, rv);
			chk(rv, 16'h0001);
			wait_valid();
			e = int'(($time - t0) / 4);
			n = (r.rate == 3'h6) ? 526 * 8
				: (r.rate == 3'h5) ? 1000 * 8 : 290 * 8;
			ok = (e >= n - 8) && (e <= n + 24);
			chk({15'h0000, ok}, 16'h0001);
			chk(res_data, r.code);
			rd(2'h1, rv);
			chk(rv, r.code);
			repeat (4) @(posedge clk);
			rd(2'h2, rv);
			chk(rv, 16'h0002);
		end
		// start written while busy, with new settings
		pattern <= 2'h1;
		wr(2'h0, 16'h07c1);
		repeat (40) @(posedge clk);
		wr(2'h0, 16'h07c4);
		#1;
		chk({13'h0000, neg_to_gnd, neg_in}, 16'h0003);
		wait_valid();
		chk(res_data, 16'h7fff);
		e = 0;
		repeat (3000)
		begin
			@(posedge clk);
			#1;
			if (res_valid === 1'b1)
				e++;
		end
		chk(16'(e), 16'h0000);
		rd(2'h0, rv);
		chk(rv, 16'h03c4);
		// continuous mode: back-to-back conversions at the data rate
		wr(2'h0, 16'h01c1);
		wait_valid();
		t0 = $time;
		@(posedge clk);
		#1;
		wait_valid();
		chk(16'(($time - t0) / 4), 16'h0910);
		rd(2'h1, rv);
		chk(rv, 16'h7fff);
		// receiver stalls until the buffer is full
		@(posedge clk);
		stall <= 1'b1;
		repeat (8000) @(posedge clk);
		wr(2'h0, 16'h03c1);
		#1;
		chk({res_valid, 15'h0000} | res_data, 16'hffff);
		@(posedge clk);
		stall <= 1'b0;
		@(posedge clk);
		#1;
		chk({res_valid, 15'h0000} | res_data, 16'hffff);
		repeat (6000) @(posedge clk);
		#1;
		chk({14'h0000, powered_down, res_valid}, 16'h0002);
		// alternating stream gives mid-scale; low enable freezes the run
		pattern <= 2'h2;
		wr(2'h0, 16'h07c0);
		@(posedge clk);
		ce <= 1'b0;
		repeat (3000) @(posedge clk);
		#1;
		chk({14'h0000, powered_down, res_valid}, 16'h0000);
		@(posedge clk);
		ce <= 1'b1;
		wait_valid();
		chk(res_data, 16'h0000);
		// second reset in the middle of a conversion
		wr(2'h0, 16'h07c1);
		repeat (50) @(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		chk({6'h00, powered_down, res_valid, neg_to_gnd, gain_out, pos_in,
			neg_in}, 16'h0221);
		rd(2'h0, rv);
		chk(rv, 16'h0310);
		tally_and_finish();
	end
endmodule // adcseq_tb_top
